// file: design/node_cfg_consts.svh
// constants for the dial switch node configuration loader
`ifndef NODE_CFG_CONSTS_SVH
`define NODE_CFG_CONSTS_SVH

// switch level that means "on" (contact closed)
`define SW_ON 1'b1
// number of address bits set by the switches
`define ADDR_LOW_W 5
// number of address bits set by the host
`define ADDR_HIGH_W 2
// broadcast / default node address
`define ADDR_BROADCAST 7'h00
// rate select codes, {rate_switch_high, rate_switch_low}, 1 = on
`define RATE_SEL_BOTH_ON 2'h3
`define RATE_SEL_LOW_OFF 2'h2
`define RATE_SEL_HIGH_OFF 2'h1
`define RATE_SEL_BOTH_OFF 2'h0
// serial rates in baud
`define BAUD_DEFAULT 17'h02580
`define BAUD_19200 17'h04b00
`define BAUD_38400 17'h09600
`define BAUD_57600 17'h0e100
// register offsets on the plain register port
`define REG_NODE_CFG 4'h0
`define REG_HOST_ADDR 4'h1
`define REG_BAUD 4'h2
// field positions in the node config register
`define FLD_ADDR_LSB 0
`define FLD_TERM_BIT 8
`define FLD_RATE_LSB 9
`define FLD_BCAST_BIT 11
`define FLD_LOADED_BIT 12
// settle cycles before the one-shot sample after reset
`define SETTLE_CYCLES 8'h10

`endif

// file: design/node_cfg_pkg.sv
// types shared by the node configuration loader
package node_cfg_pkg;
    // loader sequence states
    typedef enum logic [1:0] {
        ST_SETTLE,
        ST_SAMPLE,
        ST_HOLD
    } load_state_t;
    // serial rate selections
    typedef enum logic [1:0] {
        RATE_57600,
        RATE_38400,
        RATE_19200,
        RATE_DEFAULT
    } rate_sel_t;
endpackage : node_cfg_pkg

// file: design/switch_addr_decode.sv
// combinational decode of the dial switch positions
`timescale 1ns/1ps
`include "node_cfg_consts.svh"

module switch_addr_decode (
    // raw switch levels, 1 = on
    input wire logic [7:0] sw,
    // decoded results
    output logic [4:0] addr_low,
    output node_cfg_pkg::rate_sel_t rate_sel,
    output logic [16:0] baud,
    output logic term_on
);

    // on contributes zero, off contributes its weight, so invert each bit
    genvar i;
    generate
        for (i = 0; i < `ADDR_LOW_W; i = i + 1) begin : g_addr
            assign addr_low[i] = (sw[i] != `SW_ON);
        end
    endgenerate

    wire [1:0] rate_code;
    // position 7 is the high code bit, position 6 the low one
    assign rate_code = {sw[6], sw[5]};

    assign rate_sel = node_cfg_pkg::rate_sel_t'(rate_code);
    assign baud = (rate_code == `RATE_SEL_BOTH_ON) ? `BAUD_DEFAULT :
                  (rate_code == `RATE_SEL_LOW_OFF) ? `BAUD_19200 :
                  (rate_code == `RATE_SEL_HIGH_OFF) ? `BAUD_38400 :
                  `BAUD_57600;

    assign term_on = (sw[7] == `SW_ON);

endmodule : switch_addr_decode

// file: design/dip_switch_node_config.sv
// dial switch node configuration loader with host address extension
// Contract
// - low five address bits from switches
// - weights 1..16, off adds weight
// - host writes upper two address bits
// - address zero is default and broadcast
// - switches six, seven select serial rate
// - termination connected only when switch eight on
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "node_cfg_consts.svh"

module dip_switch_node_config (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // dial switch positions, 1 = on
    input wire logic [4:0] ADDR_SWITCH,
    input wire logic RATE_SWITCH_LOW,
    input wire logic RATE_SWITCH_HIGH,
    input wire logic TERMINATION_SWITCH,
    // register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // decoded configuration
    output logic [6:0] NODE_ADDR,
    output logic NODE_IS_BROADCAST,
    output logic [16:0] BAUD_RATE,
    output logic [1:0] RATE_SEL,
    output logic TERM_ENABLE,
    output logic CFG_LOADED
);

    ////////////////////////////////////////////////////////////////////////
    // switch decode

    // decoder results, all live copies of the switch levels
    wire [7:0] sw_all;
    wire [4:0] dec_addr_low;
    node_cfg_pkg::rate_sel_t dec_rate;
    wire [16:0] dec_baud;
    wire dec_term;

    // gather positions one to eight into one vector, position one in bit 0;
    // the decoder is pure logic, so its outputs follow the pins at once and
    // only the capture below decides when they count
    assign sw_all = {TERMINATION_SWITCH, RATE_SWITCH_HIGH, RATE_SWITCH_LOW, ADDR_SWITCH};

    switch_addr_decode u_dec (
        .sw(sw_all),
        .addr_low(dec_addr_low),
        .rate_sel(dec_rate),
        .baud(dec_baud),
        .term_on(dec_term)
    );

    ////////////////////////////////////////////////////////////////////////
    // one-shot load sequence

    node_cfg_pkg::load_state_t state_q;
    node_cfg_pkg::load_state_t state_d;
    logic [7:0] settle_q; // cycles left before sampling
    logic [7:0] settle_d;
    wire settle_done;

    // waiting a few cycles lets switch inputs settle after reset release;
    // the sequence after release is: settle count down to zero, one
    // sample cycle that loads the held registers, then hold for good.
    // the pins therefore show the dialled values a couple of cycles after
    // the count ends, and software should poll the loaded flag first
    assign settle_done = (settle_q == 8'h00);

    // next state; once held, nothing reloads until the next reset
    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        case (state_q)
            // count down settle time
            node_cfg_pkg::ST_SETTLE: begin
                if (settle_done) begin
                    state_d = node_cfg_pkg::ST_SAMPLE;
                end else begin
                    settle_d = settle_q - 8'h01;
                end
            end
            // one capture cycle
            node_cfg_pkg::ST_SAMPLE: begin
                state_d = node_cfg_pkg::ST_HOLD;
            end
            node_cfg_pkg::ST_HOLD: begin
                state_d = node_cfg_pkg::ST_HOLD;
            end
            // a stray state code falls back to settling rather than holding junk
            default: begin
                state_d = node_cfg_pkg::ST_SETTLE;
            end
        endcase
    end

    // state registers; the settle counter reloads on every reset, so a
    // mid-run reset repeats the whole load
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_q <= node_cfg_pkg::ST_SETTLE;
            settle_q <= `SETTLE_CYCLES;
        end else begin
            state_q <= state_d;
            settle_q <= settle_d;
        end
    end

    // capture is high for exactly one cycle per reset
    wire capture;
    assign capture = (state_q == node_cfg_pkg::ST_SAMPLE);

    ////////////////////////////////////////////////////////////////////////
    // captured switch settings

    logic [4:0] addr_low_q; // switch address bits
    logic [1:0] rate_q; // rate selection
    logic [16:0] baud_q; // decoded rate
    logic term_q; // termination
    logic loaded_q; // capture complete

    // switch values are caught by the clock, never by the reset itself;
    // each held value has its own short process so one path reads alone

    // all five address positions are taken in the same capture cycle
    // low address bits
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            // start at the broadcast value until the switches are read
            addr_low_q <= 5'h00;
        end else if (capture) begin
            addr_low_q <= dec_addr_low;
        end
    end

    // the rate code is kept beside its baud value for the status view
    // held rate code
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rate_q <= `RATE_SEL_BOTH_ON;
        end else if (capture) begin
            rate_q <= dec_rate;
        end
    end

    // seventeen bits hold the fastest selectable rate
    // held baud value
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            baud_q <= `BAUD_DEFAULT;
        end else if (capture) begin
            baud_q <= dec_baud;
        end
    end

    // the resistor stays disconnected until the switch has been read
    // held termination
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            term_q <= 1'b0;
        end else if (capture) begin
            term_q <= dec_term;
        end
    end

    // once set, only a reset clears it, and the load runs again only after that reset
    // capture complete flag
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            loaded_q <= 1'b0;
        end else if (capture) begin
            loaded_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host register port

    // register map, one word per index:
    //   0x0 status: loaded, broadcast, rate code, termination, node address
    //   0x1 upper node address bits, written and read back by the host
    //   0x2 decoded baud value, read only
    //   other indices read as zero and ignore writes
    // writes to the status and baud words are dropped on purpose: the
    // switches own those values and the host must not override them
    logic [1:0] addr_high_q; // host-written upper address bits
    wire wr_host_addr;

    // write decode for the one writable word
    assign wr_host_addr = REG_WR && (REG_ADDR == `REG_HOST_ADDR);

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            addr_high_q <= 2'h0;
        end else if (wr_host_addr) begin
            addr_high_q <= REG_WDATA[`ADDR_HIGH_W-1:0];
        end
    end

    // full address as the bus sees it
    wire [6:0] node_addr_w;
    wire bcast_w;

    assign node_addr_w = {addr_high_q, addr_low_q};
    // broadcast is judged on all seven bits, so host bits count as well
    // zero means broadcast
    assign bcast_w = (node_addr_w == `ADDR_BROADCAST);

    wire [31:0] cfg_word;
    wire [31:0] rd_mux;

    // status view of the held configuration
    // bit 7 stays zero as a spare between the address and the flags
    assign cfg_word = {19'h00000, loaded_q, bcast_w, rate_q, term_q, 1'b0, node_addr_w};

    // unmapped offsets read as zero
    assign rd_mux = (REG_ADDR == `REG_NODE_CFG) ? cfg_word :
                    (REG_ADDR == `REG_HOST_ADDR) ? {30'h00000000, addr_high_q} :
                    (REG_ADDR == `REG_BAUD) ? {15'h0000, baud_q} :
                    32'h00000000;

    // read data stands only in the cycle after the strobe; the zero in idle
    // cycles stops a stale word from lingering on the bus
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 32'h00000000;
        end else if (REG_RD) begin
            REG_RDATA <= rd_mux;
        end else begin
            REG_RDATA <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered configuration outputs

    // outputs from flops; they trail the held values by one cycle, which
    // costs a cycle of latency but keeps every pin free of decode glitches

    // host bits on top of the switch bits
    // combined node address
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            NODE_ADDR <= `ADDR_BROADCAST;
        end else begin
            NODE_ADDR <= node_addr_w;
        end
    end

    // high while the whole address is zero
    // broadcast flag
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            NODE_IS_BROADCAST <= 1'b1;
        end else begin
            NODE_IS_BROADCAST <= bcast_w;
        end
    end

    // the baud value a serial engine would divide down
    // held baud rate
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            BAUD_RATE <= `BAUD_DEFAULT;
        end else begin
            BAUD_RATE <= baud_q;
        end
    end

    // the raw two-position code, for logic that prefers it
    // held rate code
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            RATE_SEL <= `RATE_SEL_BOTH_ON;
        end else begin
            RATE_SEL <= rate_q;
        end
    end

    // high connects the line resistor
    // held termination
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            TERM_ENABLE <= 1'b0;
        end else begin
            TERM_ENABLE <= term_q;
        end
    end

    // tells software that the pins now show the dialled values
    // loaded indication
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            CFG_LOADED <= 1'b0;
        end else begin
            CFG_LOADED <= loaded_q;
        end
    end

endmodule : dip_switch_node_config

// file: sim/node_cfg_checker.sv
// assertion checker for the dial switch node configuration loader
`timescale 1ns/1ps
module node_cfg_checker (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // switches
    input wire logic [4:0] ADDR_SWITCH,
    input wire logic RATE_SWITCH_LOW,
    input wire logic RATE_SWITCH_HIGH,
    input wire logic TERMINATION_SWITCH,
    // register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    // decoded configuration
    input wire logic [6:0] NODE_ADDR,
    input wire logic NODE_IS_BROADCAST,
    input wire logic [16:0] BAUD_RATE,
    input wire logic [1:0] RATE_SEL,
    input wire logic TERM_ENABLE,
    input wire logic CFG_LOADED
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // baud expected for the current rate code
    wire [16:0] baud_exp = (RATE_SEL == 2'h3) ? 17'h02580 : (RATE_SEL == 2'h2) ? 17'h04b00 :
        (RATE_SEL == 2'h1) ? 17'h09600 : 17'h0e100;
    // capture moment and host write
    sequence load_edge; $rose(CFG_LOADED); endsequence
    sequence host_write; REG_WR && REG_ADDR == 4'h1 && CFG_LOADED; endsequence
    a_addr_low_map: assert property (load_edge |-> NODE_ADDR[4:0] == ~ADDR_SWITCH)
        else $error("low address off");
    a_rate_map: assert property (load_edge |-> RATE_SEL == {RATE_SWITCH_HIGH, RATE_SWITCH_LOW}
        && BAUD_RATE == baud_exp) else $error("rate off");
    a_term_map: assert property (load_edge |-> TERM_ENABLE == TERMINATION_SWITCH)
        else $error("termination off");
    a_bcast_flag: assert property (CFG_LOADED ##1 $stable(NODE_ADDR) |->
        NODE_IS_BROADCAST == (NODE_ADDR == 7'h00)) else $error("broadcast off");
    a_hold_cfg: assert property (CFG_LOADED && $past(CFG_LOADED) |-> $stable(BAUD_RATE)
        && $stable(NODE_ADDR[4:0]) && $stable(TERM_ENABLE)) else $error("config moved");
    a_host_high: assert property (host_write |-> ##2 NODE_ADDR[6:5] == $past(REG_WDATA[1:0], 2))
        else $error("host bits off");
    // read data and the pins both show the state of the strobe cycle
    a_status_read: assert property (REG_RD && REG_ADDR == 4'h0 |=> REG_RDATA[6:0] ==
        NODE_ADDR && REG_RDATA[11] == NODE_IS_BROADCAST) else $error("status off");
    a_baud_read: assert property (REG_RD && REG_ADDR == 4'h2 |=>
        REG_RDATA == {15'h0000, BAUD_RATE}) else $error("baud read off");
endmodule : node_cfg_checker

bind dip_switch_node_config node_cfg_checker i_node_cfg_checker (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .ADDR_SWITCH(ADDR_SWITCH),
    .RATE_SWITCH_LOW(RATE_SWITCH_LOW),
    .RATE_SWITCH_HIGH(RATE_SWITCH_HIGH),
    .TERMINATION_SWITCH(TERMINATION_SWITCH),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .NODE_ADDR(NODE_ADDR),
    .NODE_IS_BROADCAST(NODE_IS_BROADCAST),
    .BAUD_RATE(BAUD_RATE),
    .RATE_SEL(RATE_SEL),
    .TERM_ENABLE(TERM_ENABLE),
    .CFG_LOADED(CFG_LOADED)
);

// file: sim/host_model.sv
// host controller model driving the register port
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic CLK_SYS,
    // register port
    output logic [3:0] REG_ADDR,
    output logic [31:0] REG_WDATA,
    output logic REG_WR,
    output logic REG_RD,
    input wire logic [31:0] REG_RDATA
);
    // bus idle at time zero
    initial begin
        REG_ADDR = 4'h0;
        REG_WDATA = 32'h0;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
    end
    // one-word register write
    // released lines show the inverse so stale values never look valid
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
        REG_ADDR <= ~a;
        REG_WDATA <= ~d;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge CLK_SYS);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK_SYS);
        REG_RD <= 1'b0;
        REG_ADDR <= ~a;
        @(posedge CLK_SYS);
        d = REG_RDATA;
    endtask : rd
endmodule : host_model

// file: sim/dip_switch_node_config_test.sv
// self-checking bench for the dial switch node configuration loader
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module dip_switch_node_config_test;
    // stimulus: sw = {term, rate high, rate low, address switches}
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sw = 8'h00;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, bcast, term, loaded;
    logic [6:0] naddr;
    logic [16:0] baud;
    logic [1:0] rsel;
    int failures = 0;
    int tests_run = 0;
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    dip_switch_node_config i_dip_switch_node_config (.CLK_SYS(clk_sys), .RST(rst),
        .ADDR_SWITCH(sw[4:0]), .RATE_SWITCH_LOW(sw[5]), .RATE_SWITCH_HIGH(sw[6]),
        .TERMINATION_SWITCH(sw[7]), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .NODE_ADDR(naddr),
        .NODE_IS_BROADCAST(bcast), .BAUD_RATE(baud), .RATE_SEL(rsel),
        .TERM_ENABLE(term), .CFG_LOADED(loaded));
    host_model i_host_model (.CLK_SYS(clk_sys), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
    // reset with new switch levels, wait for capture, compare the outputs
    task automatic load(input logic [7:0] s, input logic [6:0] a, input logic [16:0] b,
        input logic t);
        @(posedge clk_sys);
        rst <= 1'b1;
        sw <= s;
        repeat (2) @(posedge clk_sys);
        `CHK({naddr, bcast, baud, term, loaded}, {7'h00, 1'b1, 17'h02580, 1'b0, 1'b0})
        rst <= 1'b0;
        for (int i = 0; i < 40 && loaded !== 1'b1; i++) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(loaded, 1'b1)
        `CHK(naddr, a)
        `CHK(bcast, a == 7'h00)
        `CHK(rsel, s[6:5])
        `CHK(baud, b)
        `CHK(term, t)
    endtask : load
    task automatic t_all_on();
        load(8'hff, 7'h00, 17'h02580, 1'b1);
    endtask : t_all_on
    // later switch moves must not reach the outputs
    task automatic t_weights_hold();
        load(8'h4a, 7'h15, 17'h04b00, 1'b0);
        @(posedge clk_sys);
        sw <= 8'hb5;
        repeat (5) @(negedge clk_sys);
        `CHK({naddr, baud, term}, {7'h15, 17'h04b00, 1'b0})
    endtask : t_weights_hold
    task automatic t_rate_38400();
        load(8'h20, 7'h1f, 17'h09600, 1'b0);
    endtask : t_rate_38400
    // host bits join the switch bits; read-only and unmapped places
    task automatic t_host_57600();
        load(8'h1f, 7'h00, 17'h0e100, 1'b0);
        i_host_model.wr(4'h1, 32'h2);
        repeat (2) @(negedge clk_sys);
        `CHK({naddr, bcast}, {7'h40, 1'b0})
        i_host_model.rd(4'h1, d);
        `CHK(d[1:0], 2'h2)
        i_host_model.wr(4'h2, 32'h0);
        i_host_model.rd(4'h2, d);
        `CHK(d, 32'h0000e100)
        i_host_model.rd(4'h0, d);
        `CHK({d[12:11], d[6:0]}, {2'h2, 7'h40})
        i_host_model.rd(4'h7, d);
        `CHK(d, 32'h0)
    endtask : t_host_57600
    task automatic stop_test();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    // watchdog far beyond the hundred-odd cycles the run needs
    initial begin
        #200000;
        failures++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_all_on();
        t_weights_hold();
        t_rate_38400();
        t_host_57600();
        stop_test();
    end
endmodule : dip_switch_node_config_test
